// >>> logic/dcprm_map.svh
// Purpose: constants for the power, refresh and mapping control block
// Assumes: one controller clock, synchronous reset
// Notes: address field widths are defaults of module parameters
`ifndef DCPRM_MAP_SVH
`define DCPRM_MAP_SVH
`define DCPRM_IDLE_W        16
`define DCPRM_IDLE_RST      16'h0000
`define DCPRM_PDX_CYC       4'h3
`define DCPRM_CMD_RD        3'h1
`define DCPRM_CMD_WR        3'h2
`define DCPRM_CMD_REF       3'h3
`define DCPRM_CMD_PDE       3'h4
`define DCPRM_CMD_PDX       3'h5
`define DCPRM_CMD_SRE       3'h6
`define DCPRM_CMD_SRX       3'h7
`define DCPRM_CMD_NONE      3'h0
`endif

// >>> logic/dcprm_pkg.sv
// Purpose: types for the power, refresh and mapping control block
// Assumes: used with dcprm_map.svh
// Notes: none
package dcprm_pkg;
  typedef enum logic [5:0] {
    DCPRM_ACTIVE = 6'h01,
    DCPRM_APD    = 6'h02,
    DCPRM_UPD    = 6'h04,
    DCPRM_SREF   = 6'h08,
    DCPRM_EXIT   = 6'h10,
    DCPRM_ISSUE  = 6'h20
  } dcprm_state_t;

  typedef enum logic {
    DCPRM_MAP_CRBC = 1'b0,
    DCPRM_MAP_CBRC = 1'b1
  } dcprm_map_t;

  typedef struct packed {
    logic [2:0]  cmd;
    logic        auto_pre;
    logic [7:0]  chip;
    logic [15:0] row;
    logic [3:0]  bank;
    logic [15:0] col;
  } dcprm_mem_cmd_t;
endpackage : dcprm_pkg

// >>> logic/dcprm_ctrl.sv
// Purpose: power-down, self-refresh, user refresh, precharge and address mapping
// Assumes: requests held until accepted; inputs synchronous to sys_clk
// Notes: one memory command is presented per accepted request
// Behaviour
// - enter power-down after programmed idle cycles
// - idle threshold sixteen bits, 1 to 65535
// - threshold zero disables automatic power-down
// - user input selects self-refresh entry
// - user input selects power-down entry
// - one refresh command per user refresh request
// - precharge flag closes row after burst
// - build-time ordering maps address to fields
// - row-before-bank lets bursts spill into next bank
// - bank-before-row puts bank in top bits
// - look-ahead depth configurable, only reported on lookahead_depth
`timescale 1ns/100ps
`include "dcprm_map.svh"
module dcprm_ctrl
  import dcprm_pkg::*;
#(
  parameter int         CS_W      = 1,
  parameter int         ROW_W     = 14,
  parameter int         BANK_W    = 3,
  parameter int         COL_W     = 10,
  parameter dcprm_map_t ADDR_MAP  = DCPRM_MAP_CRBC,
  parameter int         LOOKAHEAD = 4,
  parameter int         ADDR_W    = CS_W + ROW_W + BANK_W + COL_W
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic [`DCPRM_IDLE_W-1:0] idle_limit,
  input  wire logic                    sref_req,
  input  wire logic                    pdown_req,
  input  wire logic                    refresh_req,
  input  wire logic                    burst_req,
  input  wire logic                    burst_write,
  input  wire logic                    burst_auto_pre,
  input  wire logic [ADDR_W-1:0]       burst_addr,
  output logic                         burst_ready,
  output logic                         refresh_ack,
  output dcprm_mem_cmd_t               mem_cmd,
  output logic                         mem_cmd_valid,
  output logic                         in_power_down,
  output logic                         in_self_refresh,
  output logic [$clog2(LOOKAHEAD+1)-1:0] lookahead_depth
);

  dcprm_state_t              state;
  dcprm_state_t              next_state;
  logic [`DCPRM_IDLE_W-1:0]  idle_cnt;
  logic [3:0]                exit_cnt;
  logic                      any_req;
  logic                      low_pwr;

  // split a local address into memory fields per the build-time ordering
  function automatic dcprm_mem_cmd_t map_addr(input logic [ADDR_W-1:0] a);
    dcprm_mem_cmd_t m;
    m = '0;
    m.col  = 16'(a[COL_W-1:0]);
    m.chip = 8'(a[ADDR_W-1 -: CS_W]);
    if (ADDR_MAP == DCPRM_MAP_CRBC) begin
      // bank just above column: a burst past the column end moves to the next bank
      m.bank = 4'(a[COL_W +: BANK_W]);
      m.row  = 16'(a[COL_W+BANK_W +: ROW_W]);
    end else begin
      // bank in the top bits under chip select, one bank per requester
      m.row  = 16'(a[COL_W +: ROW_W]);
      m.bank = 4'(a[COL_W+ROW_W +: BANK_W]);
    end
    return m;
  endfunction : map_addr

  assign any_req = burst_req | refresh_req;
  assign low_pwr = (state == DCPRM_APD) | (state == DCPRM_UPD) | (state == DCPRM_SREF);

  // look-ahead depth is a build-time setting reported on lookahead_depth
  assign lookahead_depth = ($clog2(LOOKAHEAD+1))'(LOOKAHEAD);

  // handshake: requests taken only while active; refresh has priority
  assign refresh_ack = (state == DCPRM_ACTIVE) & refresh_req;
  assign burst_ready = (state == DCPRM_ACTIVE) & ~refresh_req & burst_req;

  // power state machine
  always_comb begin
    next_state = state;
    case (state)
      DCPRM_ACTIVE: begin
        if (sref_req && !any_req)
          next_state = DCPRM_SREF;
        else if (pdown_req && !any_req)
          next_state = DCPRM_UPD;
        else if (!any_req && idle_limit != '0 && idle_cnt + 16'h0001 >= idle_limit)
          next_state = DCPRM_APD;
      end
      DCPRM_APD: begin
        if (any_req || sref_req || pdown_req)
          next_state = DCPRM_EXIT;
      end
      DCPRM_UPD: begin
        if (!pdown_req)
          next_state = DCPRM_EXIT;
      end
      DCPRM_SREF: begin
        if (!sref_req)
          next_state = DCPRM_EXIT;
      end
      DCPRM_EXIT: begin
        if (exit_cnt == `DCPRM_PDX_CYC)
          next_state = DCPRM_ACTIVE;
      end
      default: next_state = DCPRM_ACTIVE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      state <= DCPRM_ACTIVE;
    else
      state <= next_state;
  end

  // idle counter: counts consecutive idle active cycles, any request clears it
  always_ff @(posedge sys_clk) begin
    if (rst)
      idle_cnt <= `DCPRM_IDLE_RST;
    else if (any_req || state != DCPRM_ACTIVE)
      idle_cnt <= `DCPRM_IDLE_RST;
    else if (idle_cnt != 16'hffff)
      idle_cnt <= idle_cnt + 16'h0001;
  end

  // exit recovery counter before servicing
  always_ff @(posedge sys_clk) begin
    if (rst || state != DCPRM_EXIT)
      exit_cnt <= 4'h0;
    else
      exit_cnt <= exit_cnt + 4'h1;
  end

  // memory command register: one command per accepted request or power transition
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_cmd       <= '0;
      mem_cmd_valid <= 1'b0;
    end else begin
      mem_cmd_valid <= 1'b0;
      mem_cmd       <= '0;
      if (refresh_ack) begin
        mem_cmd.cmd   <= `DCPRM_CMD_REF;
        mem_cmd_valid <= 1'b1;
      end else if (burst_ready) begin
        mem_cmd          <= map_addr(burst_addr);
        mem_cmd.cmd      <= burst_write ? `DCPRM_CMD_WR : `DCPRM_CMD_RD;
        mem_cmd.auto_pre <= burst_auto_pre;
        mem_cmd_valid    <= 1'b1;
      end else if (state == DCPRM_ACTIVE && next_state == DCPRM_SREF) begin
        mem_cmd.cmd   <= `DCPRM_CMD_SRE;
        mem_cmd_valid <= 1'b1;
      end else if (state == DCPRM_ACTIVE && next_state != DCPRM_ACTIVE) begin
        mem_cmd.cmd   <= `DCPRM_CMD_PDE;
        mem_cmd_valid <= 1'b1;
      end else if (low_pwr && next_state == DCPRM_EXIT) begin
        mem_cmd.cmd   <= (state == DCPRM_SREF) ? `DCPRM_CMD_SRX : `DCPRM_CMD_PDX;
        mem_cmd_valid <= 1'b1;
      end
    end
  end

  // status outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_power_down   <= 1'b0;
      in_self_refresh <= 1'b0;
    end else begin
      in_power_down   <= (next_state == DCPRM_APD) | (next_state == DCPRM_UPD);
      in_self_refresh <= (next_state == DCPRM_SREF);
    end
  end

  // power-down entered exactly when the idle count plus one reaches the limit
  property p_apd_entry;
    @(posedge sys_clk) disable iff (rst)
      (state == DCPRM_ACTIVE && !any_req && !sref_req && !pdown_req && idle_limit != '0
       && idle_cnt + 16'h0001 >= idle_limit) |=> (state == DCPRM_APD);
  endproperty
  a_apd_entry: assert property (p_apd_entry) else $error("auto power-down not entered");

  // idle count advances one per quiet active cycle
  property p_idle_count;
    @(posedge sys_clk) disable iff (rst)
      (state == DCPRM_ACTIVE && !any_req && idle_cnt != 16'hffff && next_state == DCPRM_ACTIVE)
      |=> idle_cnt == $past(idle_cnt) + 16'h0001;
  endproperty
  a_idle_count: assert property (p_idle_count) else $error("idle count not advancing");

  // a zero limit never leads to automatic power-down
  property p_zero_disables;
    @(posedge sys_clk) disable iff (rst)
      (idle_limit == '0 && state == DCPRM_ACTIVE && !sref_req && !pdown_req)
      |=> state != DCPRM_APD;
  endproperty
  a_zero_disables: assert property (p_zero_disables) else $error("zero limit slept");

  // self-refresh request taken while idle enters self-refresh
  property p_sref;
    @(posedge sys_clk) disable iff (rst)
      (state == DCPRM_ACTIVE && sref_req && !any_req) |=> in_self_refresh && mem_cmd_valid
      && mem_cmd.cmd == `DCPRM_CMD_SRE;
  endproperty
  a_sref: assert property (p_sref) else $error("self-refresh not entered");

  // user power-down request taken while idle
  property p_upd;
    @(posedge sys_clk) disable iff (rst)
      (state == DCPRM_ACTIVE && pdown_req && !sref_req && !any_req) |=> in_power_down;
  endproperty
  a_upd: assert property (p_upd) else $error("user power-down not entered");

  // each accepted refresh yields a refresh command
  property p_refresh_once;
    @(posedge sys_clk) disable iff (rst)
      refresh_ack |=> mem_cmd_valid && mem_cmd.cmd == `DCPRM_CMD_REF;
  endproperty
  a_refresh_once: assert property (p_refresh_once) else $error("refresh not issued");

  // precharge flag travels with the burst command
  property p_auto_pre;
    @(posedge sys_clk) disable iff (rst)
      burst_ready |=> mem_cmd_valid && mem_cmd.auto_pre == $past(burst_auto_pre);
  endproperty
  a_auto_pre: assert property (p_auto_pre) else $error("precharge flag lost");

  // a request wakes the memory, which returns to active after recovery
  property p_wake;
    @(posedge sys_clk) disable iff (rst)
      (state == DCPRM_APD && any_req) |=> state == DCPRM_EXIT ##[1:5] state == DCPRM_ACTIVE;
  endproperty
  a_wake: assert property (p_wake) else $error("no exit from power-down");

  // nothing is taken while asleep or recovering
  property p_refused;
    @(posedge sys_clk) disable iff (rst)
      (state != DCPRM_ACTIVE) |-> !burst_ready && !refresh_ack;
  endproperty
  a_refused: assert property (p_refused) else $error("request taken while asleep");

  // every refresh command answers one accepted request
  property p_ref_source;
    @(posedge sys_clk) disable iff (rst)
      (mem_cmd_valid && mem_cmd.cmd == `DCPRM_CMD_REF) |-> $past(refresh_ack);
  endproperty
  a_ref_source: assert property (p_ref_source) else $error("refresh without request");

  // without the flag the row is left open after the burst
  property p_row_open;
    @(posedge sys_clk) disable iff (rst)
      (burst_ready && !burst_auto_pre) |=> !mem_cmd.auto_pre;
  endproperty
  a_row_open: assert property (p_row_open) else $error("row closed without flag");

  // column field is the low local address bits in both orderings
  property p_col_map;
    @(posedge sys_clk) disable iff (rst)
      burst_ready |=> mem_cmd.col == 16'($past(burst_addr[COL_W-1:0]));
  endproperty
  a_col_map: assert property (p_col_map) else $error("column field misplaced");

  // bank field sits above the column or under chip select, per ordering
  property p_bank_map;
    @(posedge sys_clk) disable iff (rst)
      burst_ready |=> mem_cmd.bank == ((ADDR_MAP == DCPRM_MAP_CRBC)
        ? 4'($past(burst_addr[COL_W +: BANK_W])) : 4'($past(burst_addr[COL_W+ROW_W +: BANK_W])));
  endproperty
  a_bank_map: assert property (p_bank_map) else $error("bank field misplaced");

  // the two sleep flags never stand together
  property p_status_excl;
    @(posedge sys_clk) disable iff (rst)
      !(in_power_down && in_self_refresh);
  endproperty
  a_status_excl: assert property (p_status_excl) else $error("both sleep flags");

  // self-refresh ends with one exit command once the input drops
  property p_sref_exit;
    @(posedge sys_clk) disable iff (rst)
      (state == DCPRM_SREF && !sref_req) |=> state == DCPRM_EXIT && !in_self_refresh
      && mem_cmd_valid && mem_cmd.cmd == `DCPRM_CMD_SRX;
  endproperty
  a_sref_exit: assert property (p_sref_exit) else $error("self-refresh not left");

  // user power-down holds while its input stays high
  property p_upd_hold;
    @(posedge sys_clk) disable iff (rst)
      (state == DCPRM_UPD && pdown_req) |=> state == DCPRM_UPD && in_power_down;
  endproperty
  a_upd_hold: assert property (p_upd_hold) else $error("user power-down dropped");

  // any request restarts the idle count
  property p_idle_clear;
    @(posedge sys_clk) disable iff (rst)
      any_req |=> idle_cnt == `DCPRM_IDLE_RST;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle count kept");

  // recovery runs its full count before service resumes
  property p_exit_len;
    @(posedge sys_clk) disable iff (rst)
      (state == DCPRM_EXIT && exit_cnt != `DCPRM_PDX_CYC) |=> state == DCPRM_EXIT;
  endproperty
  a_exit_len: assert property (p_exit_len) else $error("recovery cut short");

endmodule : dcprm_ctrl

// >>> dv/dcprm_mem_model.sv
// Purpose: behavioural memory device that follows the controller command stream
// Assumes: one command per mem_cmd_valid pulse
// Notes: counts refreshes and flags accesses made while the device sleeps
`timescale 1ns/100ps
`include "dcprm_map.svh"
module dcprm_mem_model
  import dcprm_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           rst,
  input  wire dcprm_mem_cmd_t mem_cmd,
  input  wire logic           mem_cmd_valid,
  output logic [7:0]          ref_cnt,
  output logic [2:0]          last_cmd,
  output logic [7:0]          n_bad
);
  logic asleep;

  // track sleep state; a read, write or refresh while asleep is illegal
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_cnt  <= 8'h00;
      last_cmd <= `DCPRM_CMD_NONE;
      n_bad    <= 8'h00;
      asleep   <= 1'b0;
    end else if (mem_cmd_valid) begin
      last_cmd <= mem_cmd.cmd;
      if (mem_cmd.cmd == `DCPRM_CMD_REF) ref_cnt <= ref_cnt + 8'h01;
      if (mem_cmd.cmd == `DCPRM_CMD_PDE || mem_cmd.cmd == `DCPRM_CMD_SRE) asleep <= 1'b1;
      if (mem_cmd.cmd == `DCPRM_CMD_PDX || mem_cmd.cmd == `DCPRM_CMD_SRX) asleep <= 1'b0;
      if (asleep && mem_cmd.cmd inside {`DCPRM_CMD_RD, `DCPRM_CMD_WR, `DCPRM_CMD_REF})
        n_bad <= n_bad + 8'h01;
    end
  end
endmodule : dcprm_mem_model

// >>> dv/tb.sv
// Purpose: self-checking bench for the power, refresh and mapping block
// Assumes: 28-bit local address; a second copy runs chip|bank|row|col ordering
// Notes: random bursts among corner addresses; model watches the command stream
`timescale 1ns/100ps
`include "dcprm_map.svh"
module tb
  import dcprm_pkg::*;
;
  localparam int AW = 28;
  logic sys_clk = 1'b0, rst = 1'b1, sref_req = 1'b0, pdown_req = 1'b0, refresh_req = 1'b0;
  logic burst_req = 1'b0, burst_write = 1'b0, burst_auto_pre = 1'b0;
  logic [15:0] idle_limit = 16'h0000;
  logic [AW-1:0] burst_addr = '0;
  logic burst_ready, refresh_ack, mem_cmd_valid, in_power_down, in_self_refresh;
  logic [2:0] lookahead_depth, last_cmd;
  logic [7:0] ref_cnt, n_bad;
  dcprm_mem_cmd_t mem_cmd, mem_cmd_b;
  int n_errors = 0, total_checks = 0;

  always #50 sys_clk = ~sys_clk;

  dcprm_ctrl #(.LOOKAHEAD(4)) dcprm_ctrl_i (.sys_clk(sys_clk), .rst(rst),
    .idle_limit(idle_limit), .sref_req(sref_req), .pdown_req(pdown_req),
    .refresh_req(refresh_req), .burst_req(burst_req), .burst_write(burst_write),
    .burst_auto_pre(burst_auto_pre), .burst_addr(burst_addr), .burst_ready(burst_ready),
    .refresh_ack(refresh_ack), .mem_cmd(mem_cmd), .mem_cmd_valid(mem_cmd_valid),
    .in_power_down(in_power_down), .in_self_refresh(in_self_refresh),
    .lookahead_depth(lookahead_depth));
  // same stimulus, other ordering: only the mapped fields may differ
  dcprm_ctrl #(.LOOKAHEAD(4), .ADDR_MAP(DCPRM_MAP_CBRC)) dcprm_ctrl_cbrc_i (.sys_clk(sys_clk),
    .rst(rst), .idle_limit(idle_limit), .sref_req(sref_req), .pdown_req(pdown_req),
    .refresh_req(refresh_req), .burst_req(burst_req), .burst_write(burst_write),
    .burst_auto_pre(burst_auto_pre), .burst_addr(burst_addr), .burst_ready(),
    .refresh_ack(), .mem_cmd(mem_cmd_b), .mem_cmd_valid(), .in_power_down(),
    .in_self_refresh(), .lookahead_depth());
  dcprm_mem_model dcprm_mem_model_i (.sys_clk(sys_clk), .rst(rst), .mem_cmd(mem_cmd),
    .mem_cmd_valid(mem_cmd_valid), .ref_cnt(ref_cnt), .last_cmd(last_cmd), .n_bad(n_bad));

  task automatic test_done();
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cmd(input dcprm_mem_cmd_t got, input dcprm_mem_cmd_t exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t command %h expected %h", $time, got, exp);
    end
  endtask : chk_cmd

  // expected memory command for a burst; cb picks chip|bank|row|col ordering
  function automatic dcprm_mem_cmd_t exp_cmd(input logic wr, ap, cb, input logic [AW-1:0] a);
    exp_cmd = '0;
    exp_cmd.cmd = wr ? `DCPRM_CMD_WR : `DCPRM_CMD_RD;
    exp_cmd.auto_pre = ap;
    exp_cmd.chip = {7'h00, a[27]};
    exp_cmd.row = cb ? {2'h0, a[23:10]} : {2'h0, a[26:13]};
    exp_cmd.bank = cb ? {1'h0, a[26:24]} : {1'h0, a[12:10]};
    exp_cmd.col = {6'h00, a[9:0]};
  endfunction : exp_cmd

  function automatic logic sel(input int k);
    case (k)
      0: sel = burst_ready;
      1: sel = refresh_ack;
      2: sel = in_power_down;
      default: sel = in_self_refresh;
    endcase
  endfunction : sel

  // bounded wait at falling edges; n returns the cycles waited
  task automatic wait_for(input int k, input logic lvl, output int n);
    n = 0;
    while (sel(k) !== lvl && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 200) chk_val(32'h0, 32'h1);
  endtask : wait_for

  task automatic burst(input logic wr, ap, input logic [AW-1:0] a);
    int n;
    @(posedge sys_clk);
    burst_req <= 1'b1;
    burst_write <= wr;
    burst_auto_pre <= ap;
    burst_addr <= a;
    @(negedge sys_clk);
    wait_for(0, 1'b1, n);
    @(posedge sys_clk);
    burst_req <= 1'b0;
    @(negedge sys_clk);
    chk_val(mem_cmd_valid, 1);
    chk_cmd(mem_cmd, exp_cmd(wr, ap, 1'b0, a));
    chk_cmd(mem_cmd_b, exp_cmd(wr, ap, 1'b1, a));
  endtask : burst

  task automatic refresh();
    int n;
    @(posedge sys_clk);
    refresh_req <= 1'b1;
    @(negedge sys_clk);
    wait_for(1, 1'b1, n);
    @(posedge sys_clk);
    refresh_req <= 1'b0;
    @(negedge sys_clk);
    chk_val(mem_cmd_valid, 1);
    chk_cmd(mem_cmd, dcprm_mem_cmd_t'{cmd: `DCPRM_CMD_REF, default: '0});
  endtask : refresh

  // watchdog sized well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end

  initial begin
    int n;
    logic [AW-1:0] a;
    n = $urandom(32'hb6c94322);
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk_val(lookahead_depth, 4);
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? '0 : (i == 1) ? '1 : AW'($urandom);
      if (i == 2) a = 28'h00003ff; // last column of bank 0
      if (i == 3) a = 28'h0000400; // next column spills into bank 1
      burst(i[0], 1'($urandom), a);
    end
    repeat (3) refresh();
    repeat (100) @(negedge sys_clk);
    chk_val(in_power_down, 0);
    chk_val(last_cmd, `DCPRM_CMD_REF);
    @(posedge sys_clk);
    idle_limit <= 16'h0005;
    burst(1'b1, 1'b0, AW'($urandom));
    wait_for(2, 1'b1, n);
    @(negedge sys_clk);
    chk_val(n, 5);
    chk_val(last_cmd, `DCPRM_CMD_PDE);
    burst(1'b0, 1'b1, AW'($urandom));
    @(posedge sys_clk);
    idle_limit <= 16'h0000;
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      if (k == 0) sref_req <= 1'b1;
      else pdown_req <= 1'b1;
      wait_for(3 - k, 1'b1, n);
      @(negedge sys_clk);
      chk_val(last_cmd, k ? `DCPRM_CMD_PDE : `DCPRM_CMD_SRE);
      @(posedge sys_clk);
      sref_req <= 1'b0;
      pdown_req <= 1'b0;
      wait_for(3 - k, 1'b0, n);
      @(negedge sys_clk);
      chk_val(last_cmd, k ? `DCPRM_CMD_PDX : `DCPRM_CMD_SRX);
    end
    // lowest legal limit: one quiet cycle sends it to sleep, a refresh wakes it
    @(posedge sys_clk);
    idle_limit <= 16'h0001;
    wait_for(2, 1'b1, n);
    @(negedge sys_clk);
    chk_val(last_cmd, `DCPRM_CMD_PDE);
    refresh();
    repeat (3) @(negedge sys_clk);
    chk_val(ref_cnt, 4);
    chk_val(n_bad, 0);
    test_done();
  end
endmodule : tb
